/* bench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Host processor at the far side of the interrupt pins
// ============================================================
// Byte accesses only, one strobe per access. Idle lines show the inverse
// of the last value, so a stale address never looks like a live request.
module host_model
    import accel_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic irq_out_first,
    input wire logic irq_out_second,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en
);
    // Quiet bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // One write, held through exactly one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask

    // One read; the answer stands from the cycle after the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
    endtask

    // Disable first, change the setting, enable last: avoids a stray pulse
    task automatic reconf(input logic [7:0] en, input logic [7:0] a, input logic [7:0] d);
        wr(IRQ_ENABLE_BITS_ADDR, NO_BITS);
        wr(a, d);
        wr(IRQ_ENABLE_BITS_ADDR, en);
    endtask
endmodule // host_model

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Compare helper: counts every check, reports a mismatch at once
// ============================================================
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
    $display("[ERR] %s expected %h seen %h", nm, e, s); bad_count++; end end

module tb_top
    import accel_irq_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sample_new = 1'b0;
    logic [8*SAMPLE_BYTES-1:0] sample_data = '0;
    logic [7:0] knock_level = 8'h00;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic reg_wr_en, reg_rd_en, irq_out_first, irq_out_second;
    int bad_count = 0;
    int n_checks = 0;
    integer seed = 32'h3505;
    logic [7:0] exp_v[$]; // Expected read answers, oldest first
    string exp_n[$]; // Names of those answers
    logic rd_pend = 1'b0; // A read was taken at the last edge
    logic [47:0] last_data; // Bytes of the newest sample sent
    logic [7:0] regs[6] = '{KNOCK_THRESHOLD_ADDR, KNOCK_MAX_DURATION_ADDR,
        IRQ_ENABLE_BITS_ADDR, IRQ_ROUTE_BITS_ADDR, IRQ_CAUSE_BITS_ADDR,
        OUTPUT_FORMAT_CTRL_ADDR};
    int run[5] = '{1, 2, 3, 2, 1}; // Samples sent at the run's level in each knock run
    logic [7:0] lvl[5] = '{8'h41, 8'h41, 8'h41, 8'h40, 8'hff};
    logic hit[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1}; // Run of 3 hits duration

    // ============================================================
    // Clock, design and host
    // ============================================================
    always #2.5 ref_clk = ~ref_clk;

    accel_interrupt_logic i_accel_interrupt_logic (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .sample_new(sample_new),
        .sample_data(sample_data), .knock_level(knock_level),
        .irq_out_first(irq_out_first), .irq_out_second(irq_out_second));

    host_model i_host_model (.ref_clk(ref_clk), .irq_out_first(irq_out_first),
        .irq_out_second(irq_out_second), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));

    // ============================================================
    // Result watcher: takes the oldest note whenever an answer stands
    // ============================================================
    always @(posedge ref_clk) begin : mon
        logic [7:0] ev;
        string en;
        if (rd_pend && exp_v.size() > 0) begin
            ev = exp_v.pop_front();
            en = exp_n.pop_front();
            `CHK(en, ev, reg_rd_data)
        end
        rd_pend <= reg_rd_en;
    end

    // Verdict and end of run, from one place only
    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Note the expected answer, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        exp_v.push_back(e);
        exp_n.push_back(nm);
        i_host_model.rd(a);
        @(posedge ref_clk);
    endtask

    // Pins are levels: give the two-cycle path time to settle first
    task automatic pins(input logic f, input logic s, input string nm);
        repeat (3) @(posedge ref_clk);
        `CHK({nm, " first"}, f, irq_out_first)
        `CHK({nm, " second"}, s, irq_out_second)
    endtask

    // One sample pulse with fresh random bytes
    task automatic smp(input logic [7:0] l);
        last_data = {16'($random(seed)), 32'($random(seed))};
        @(posedge ref_clk);
        sample_new <= 1'b1;
        knock_level <= l;
        sample_data <= last_data;
        @(posedge ref_clk);
        sample_new <= 1'b0;
        knock_level <= ~l; // Ignored outside the pulse
    endtask

    // Hang guard: a run that never ends counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk);
        $display("[ERR] run length expected done seen hang");
        bad_count++;
        test_done();
    end

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin : main
        logic [7:0] v;
        int i;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        pins(1'b0, 1'b0, "reset pins");
        // Reset values, read back, refused writes to the cause register
        for (i = 0; i < 6; i++) begin
            rd(regs[i], REG_RESET, "reset value");
            v = 8'($random(seed));
            i_host_model.wr(regs[i], v);
            rd(regs[i], (i == 4) ? NO_BITS : v, "read back");
            i_host_model.wr(regs[i], REG_RESET);
        end
        i_host_model.wr(8'h40, 8'h5a);
        rd(8'h40, NO_BITS, "unmapped");
        // New sample routed to the first pin
        i_host_model.reconf(8'h80, IRQ_ROUTE_BITS_ADDR, NO_BITS);
        smp(8'h00);
        pins(1'b1, 1'b0, "ready first");
        rd(IRQ_CAUSE_BITS_ADDR, 8'h80, "cause ready");
        rd(IRQ_CAUSE_BITS_ADDR, 8'h80, "cause kept");
        for (i = 0; i < 5; i++) begin
            rd(8'(SAMPLE_FIRST_ADDR + i), last_data[8*i +: 8], "sample byte");
        end
        pins(1'b1, 1'b0, "ready held");
        rd(SAMPLE_LAST_ADDR, last_data[47:40], "last byte");
        pins(1'b0, 1'b0, "ready consumed");
        // Disabled flag stays off the pins; then second pin and polarity
        i_host_model.wr(IRQ_ENABLE_BITS_ADDR, NO_BITS);
        smp(8'h00);
        pins(1'b0, 1'b0, "ready disabled");
        i_host_model.reconf(8'h80, IRQ_ROUTE_BITS_ADDR, 8'h80);
        pins(1'b0, 1'b1, "ready second");
        i_host_model.wr(OUTPUT_FORMAT_CTRL_ADDR, 8'h20);
        pins(1'b1, 1'b0, "flipped");
        rd(SAMPLE_LAST_ADDR, last_data[47:40], "last byte");
        pins(1'b1, 1'b1, "flipped idle");
        i_host_model.wr(OUTPUT_FORMAT_CTRL_ADDR, REG_RESET);
        // Knock runs against threshold and maximum duration
        i_host_model.wr(KNOCK_THRESHOLD_ADDR, 8'h40);
        i_host_model.wr(KNOCK_MAX_DURATION_ADDR, 8'h03);
        i_host_model.reconf(8'hc0, IRQ_ROUTE_BITS_ADDR, 8'h80);
        for (i = 0; i < 5; i++) begin
            repeat (run[i]) smp(lvl[i]);
            smp(8'h40); // At threshold counts as not above
            pins(hit[i], 1'b1, "knock run");
            rd(SAMPLE_LAST_ADDR, last_data[47:40], "last byte");
            pins(hit[i], 1'b0, "knock latched");
            rd(IRQ_CAUSE_BITS_ADDR, {1'b0, hit[i], 6'h00}, "cause knock");
            rd(IRQ_CAUSE_BITS_ADDR, NO_BITS, "cause cleared");
            pins(1'b0, 1'b0, "knock cleared");
        end
        // Both flags share the first pin
        i_host_model.reconf(8'hc0, IRQ_ROUTE_BITS_ADDR, NO_BITS);
        smp(8'h41);
        smp(8'h40);
        pins(1'b1, 1'b0, "shared first");
        rd(IRQ_CAUSE_BITS_ADDR, 8'hc0, "cause both");
        pins(1'b1, 1'b0, "ready alone");
        rd(SAMPLE_LAST_ADDR, last_data[47:40], "last byte");
        pins(1'b0, 1'b0, "shared cleared");
        // Second reset in mid-run wipes flags and settings
        smp(8'h00);
        @(posedge ref_clk);
        reset <= 1'b1;
        pins(1'b0, 1'b0, "mid reset");
        reset <= 1'b0;
        rd(IRQ_ENABLE_BITS_ADDR, REG_RESET, "enable after reset");
        rd(IRQ_CAUSE_BITS_ADDR, NO_BITS, "cause after reset");
        test_done();
    end
endmodule // tb_top

`default_nettype wire

/* rtl/accel_interrupt_logic.sv */
`timescale 1ns/1ps
`default_nettype none

// Interrupt logic of the accelerometer: two latched sources, an enable
// and a routing bit per source, two push-pull pins with a shared
// polarity, and the register port through which the host reaches it.
module accel_interrupt_logic
    import accel_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    input wire logic sample_new,
    input wire logic [8*SAMPLE_BYTES-1:0] sample_data,
    input wire logic [7:0] knock_level,
    output logic irq_out_first,
    output logic irq_out_second
);

    // ========================================================
    // Register storage
    // ========================================================
    logic [7:0] knock_threshold_q;    // Knock threshold
    logic [7:0] knock_max_duration_q; // Knock maximum duration
    logic [7:0] irq_enable_bits_q;    // One enable per source
    logic [7:0] irq_route_bits_q;     // 0 sends to first pin, 1 to second
    logic [7:0] output_format_ctrl_q; // Holds the polarity flip
    logic [8*SAMPLE_BYTES-1:0] sample_q; // Newest sample held for reads
    logic [7:0] rd_data_q;            // Read answer
    logic ready_q;                    // Latched sample-available flag
    logic knock_q;                    // Latched single-knock flag
    logic irq_first_q;                // First pin level
    logic irq_second_q;               // Second pin level

    // ========================================================
    // Address decode
    // ========================================================
    logic wr_thr;      // Write to knock threshold
    logic wr_dur;      // Write to knock duration
    logic wr_en_reg;   // Write to enable register
    logic wr_route;    // Write to routing register
    logic wr_fmt;      // Write to output format
    logic in_sample;   // Address lies in the sample bytes
    logic cause_rd;    // Host reads the cause register
    logic last_rd;     // Host reads the last sample byte
    logic [2:0] byte_idx; // Sample byte selected by the address

    assign wr_thr = reg_wr_en && (reg_addr == KNOCK_THRESHOLD_ADDR);
    assign wr_dur = reg_wr_en && (reg_addr == KNOCK_MAX_DURATION_ADDR);
    assign wr_en_reg = reg_wr_en && (reg_addr == IRQ_ENABLE_BITS_ADDR);
    assign wr_route = reg_wr_en && (reg_addr == IRQ_ROUTE_BITS_ADDR);
    assign wr_fmt = reg_wr_en && (reg_addr == OUTPUT_FORMAT_CTRL_ADDR);
    assign in_sample = (reg_addr >= SAMPLE_FIRST_ADDR) && (reg_addr <= SAMPLE_LAST_ADDR);
    assign cause_rd = reg_rd_en && (reg_addr == IRQ_CAUSE_BITS_ADDR);
    // One sample buffer only: reading its last byte leaves nothing unread
    assign last_rd = reg_rd_en && (reg_addr == SAMPLE_LAST_ADDR);
    assign byte_idx = 3'(reg_addr - SAMPLE_FIRST_ADDR);

    // ========================================================
    // Event sources
    // ========================================================
    logic knock_hit; // One-cycle knock event from the detector

    knock_detector #(
        .RUN_W(8)
    ) u_knock (
        .ref_clk(ref_clk),
        .reset(reset),
        .sample_new(sample_new),
        .knock_level(knock_level),
        .knock_threshold(knock_threshold_q),
        .knock_max_duration(knock_max_duration_q),
        .knock_hit(knock_hit)
    );

    // ========================================================
    // Flag latches
    // ========================================================
    logic ready_d; // Next sample-available flag
    logic knock_d; // Next single-knock flag

    // A new sample in the cycle of the consuming read must not be lost,
    // so the set term wins over the clear
    assign ready_d = sample_new || (ready_q && !last_rd);
    // Only the cause read clears the knock flag; data reads leave it
    assign knock_d = knock_hit || (knock_q && !cause_rd);

    // Flags latch whether or not they are enabled, so the cause
    // register tells the host what happened even on masked sources
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b0;
            knock_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
            knock_q <= knock_d;
        end
    end

    // ========================================================
    // Cause vector and pin gating
    // ========================================================
    logic [7:0] cause_bits;   // Latched flags at their bit positions
    logic [7:0] pend_bits;    // Flags that are also enabled
    logic first_lvl;          // Any enabled flag routed to first pin
    logic second_lvl;         // Any enabled flag routed to second pin
    logic flip;               // Active-low output selected

    assign cause_bits = ({7'h00, ready_q} << SAMPLE_READY_BIT)
                      | ({7'h00, knock_q} << KNOCK_BIT);
    assign pend_bits = cause_bits & irq_enable_bits_q;
    assign first_lvl = |(pend_bits & ~irq_route_bits_q);
    assign second_lvl = |(pend_bits & irq_route_bits_q);
    assign flip = output_format_ctrl_q[POLARITY_FLIP_BIT];

    // Pins come from flops so a decode glitch never reaches the host;
    // reset leaves them low, which is inactive in active-high mode
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_first_q <= 1'b0;
            irq_second_q <= 1'b0;
        end else begin
            irq_first_q <= first_lvl ^ flip;
            irq_second_q <= second_lvl ^ flip;
        end
    end

    // Both pins are plain outputs that are driven at all times
    assign irq_out_first = irq_first_q;
    assign irq_out_second = irq_second_q;

    // ========================================================
    // Register writes
    // ========================================================
    // Writes take effect at once; the host is expected to disable a
    // source before changing its setup, so no shadowing is done here
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            knock_threshold_q <= REG_RESET;
            knock_max_duration_q <= REG_RESET;
            irq_enable_bits_q <= REG_RESET;
            irq_route_bits_q <= REG_RESET;
            output_format_ctrl_q <= REG_RESET;
        end else begin
            if (wr_thr) begin
                knock_threshold_q <= reg_wr_data;
            end
            if (wr_dur) begin
                knock_max_duration_q <= reg_wr_data;
            end
            if (wr_en_reg) begin
                irq_enable_bits_q <= reg_wr_data;
            end
            if (wr_route) begin
                irq_route_bits_q <= reg_wr_data;
            end
            if (wr_fmt) begin
                output_format_ctrl_q <= reg_wr_data;
            end
        end
    end

    // Sample holding register, refreshed on every new sample
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sample_q <= '0;
        end else if (sample_new) begin
            sample_q <= sample_data;
        end
    end

    // ========================================================
    // Register reads
    // ========================================================
    logic [7:0] rd_mux; // Value selected by the address

    // Unmapped addresses and the cause register's spare bits read zero
    assign rd_mux = (reg_addr == KNOCK_THRESHOLD_ADDR) ? knock_threshold_q :
                    (reg_addr == KNOCK_MAX_DURATION_ADDR) ? knock_max_duration_q :
                    (reg_addr == IRQ_ENABLE_BITS_ADDR) ? irq_enable_bits_q :
                    (reg_addr == IRQ_ROUTE_BITS_ADDR) ? irq_route_bits_q :
                    (reg_addr == IRQ_CAUSE_BITS_ADDR) ? cause_bits :
                    (reg_addr == OUTPUT_FORMAT_CTRL_ADDR) ? output_format_ctrl_q :
                    in_sample ? sample_q[8*byte_idx +: 8] :
                    NO_BITS;

    // The answer is captured with the read strobe and holds until the
    // next read; it shows the flags before the read's own clearing
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= REG_RESET;
        end else if (reg_rd_en) begin
            rd_data_q <= rd_mux;
        end
    end

    assign reg_rd_data = rd_data_q;

    // ========================================================
    // Checks
    // ========================================================
    property p_flag_latched;
        @(posedge ref_clk) disable iff (reset)
        ready_q && !last_rd |=> ready_q;
    endproperty
    a_flag_latched: assert property (p_flag_latched)
        else $error("sample flag dropped without a consuming read");

    property p_sample_sets;
        @(posedge ref_clk) disable iff (reset)
        sample_new |=> ready_q ##1 (ready_q || $past(last_rd));
    endproperty
    a_sample_sets: assert property (p_sample_sets)
        else $error("new sample did not raise the sample flag");

    property p_data_clear;
        @(posedge ref_clk) disable iff (reset)
        ready_q && last_rd && !sample_new |=> !ready_q;
    endproperty
    a_data_clear: assert property (p_data_clear)
        else $error("last sample byte read left the sample flag set");

    property p_cause_clear;
        @(posedge ref_clk) disable iff (reset)
        knock_q && cause_rd && !knock_hit |=> !knock_q && (ready_q == $past(ready_d));
    endproperty
    a_cause_clear: assert property (p_cause_clear)
        else $error("cause read did not clear the knock flag");

    property p_knock_sets;
        @(posedge ref_clk) disable iff (reset)
        knock_hit |=> knock_q && cause_bits[KNOCK_BIT];
    endproperty
    a_knock_sets: assert property (p_knock_sets)
        else $error("knock event not latched into the cause register");

    property p_disabled_quiet;
        @(posedge ref_clk) disable iff (reset)
        irq_enable_bits_q == NO_BITS |=>
            (irq_out_first == $past(flip)) && (irq_out_second == $past(flip));
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("pin active while no source is enabled");

    property p_route_second;
        @(posedge ref_clk) disable iff (reset)
        (pend_bits != NO_BITS) && ((pend_bits & ~irq_route_bits_q) == NO_BITS) |=>
            (irq_out_second != $past(flip)) && (irq_out_first == $past(flip));
    endproperty
    a_route_second: assert property (p_route_second)
        else $error("pending flag routed to second pin showed on the wrong pin");

    property p_active_high;
        @(posedge ref_clk) disable iff (reset)
        !flip && ((pend_bits & ~irq_route_bits_q) != NO_BITS) |=> irq_out_first;
    endproperty
    a_active_high: assert property (p_active_high)
        else $error("first pin not high for a pending enabled flag");

    property p_flipped_low;
        @(posedge ref_clk) disable iff (reset)
        flip && second_lvl |=> !irq_out_second;
    endproperty
    a_flipped_low: assert property (p_flipped_low)
        else $error("second pin not low in active-low mode");

endmodule // accel_interrupt_logic

`default_nettype wire

/* rtl/knock_detector.sv */
`timescale 1ns/1ps
`default_nettype none

// Measures how many samples in a row exceed the threshold and flags a
// knock when the run ends before the maximum duration is reached.
module knock_detector
    import accel_irq_pkg::*;
#(
    parameter int RUN_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sample_new,
    input wire logic [7:0] knock_level,
    input wire logic [7:0] knock_threshold,
    input wire logic [7:0] knock_max_duration,
    output logic knock_hit
);

    // ========================================================
    // Parameter check
    // ========================================================
    // The run counter must cover the full 8-bit duration range
    if (RUN_W < 8) begin : g_bad_width
        $error("knock_detector: RUN_W must be at least 8");
    end

    // ========================================================
    // Decode
    // ========================================================
    knock_state_t state_q;   // Current detector state
    knock_state_t state_d;   // Next detector state
    logic [RUN_W-1:0] run_q; // Samples seen above threshold
    logic [RUN_W-1:0] run_d; // Next run length
    logic [RUN_W-1:0] dur_w; // Duration widened to counter width
    logic above;             // This sample is over the threshold
    logic dropped;           // This sample ended a run
    logic hit_w;             // Run ended short enough to count

    assign dur_w = RUN_W'(knock_max_duration);
    assign above = sample_new && (knock_level > knock_threshold);
    assign dropped = sample_new && !above;
    // A zero duration can never be undercut, so it disables knocks
    assign hit_w = (state_q == KNOCK_ABOVE) && dropped && (run_q < dur_w);

    // Next state; only sample strobes move the detector
    always_comb begin
        state_d = state_q;
        run_d = run_q;
        case (state_q)
            KNOCK_IDLE: begin
                if (above) begin
                    state_d = KNOCK_ABOVE;
                    run_d = RUN_W'(1);
                end
            end
            KNOCK_ABOVE: begin
                if (dropped) begin
                    state_d = KNOCK_IDLE;
                end else if (above) begin
                    // Too long a run is a push, not a knock
                    if (run_q >= dur_w) begin
                        state_d = KNOCK_LONG;
                    end else begin
                        run_d = run_q + RUN_W'(1);
                    end
                end
            end
            KNOCK_LONG: begin
                if (dropped) begin
                    state_d = KNOCK_IDLE;
                end
            end
            default: begin
                state_d = KNOCK_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= KNOCK_IDLE;
            run_q <= '0;
        end else begin
            state_q <= state_d;
            run_q <= run_d;
        end
    end

    assign knock_hit = hit_w;

    // ========================================================
    // Checks
    // ========================================================
    property p_knock_short;
        @(posedge ref_clk) disable iff (reset)
        knock_hit |-> (state_q == KNOCK_ABOVE) && sample_new && (run_q != '0)
            && (run_q < dur_w) && (knock_level <= knock_threshold);
    endproperty
    a_knock_short: assert property (p_knock_short)
        else $error("knock reported for a run that was not short and above threshold");

endmodule // knock_detector

`default_nettype wire

/* shared/accel_irq_pkg.sv */
// Function
// - Two separate interrupt output pins exist
// - Both pins always driven, push-pull
// - After reset both pins active high
// - Polarity-flip bit makes both pins active low
// - Function reaches pin only when enabled
// - Routing bit picks first or second pin
// - All functions run together, sharing pins
// - Flags stay latched until their clearing action
// - Data flags clear when sample reads consume data
// - Cause register read clears non-data flags
// - Cause register shows every enableable function
// - Sample flag set on new sample, cleared when consumed
// - Knock flag: above threshold, shorter than duration

`default_nettype none

package accel_irq_pkg;

    // ========================================================
    // Register offsets
    // ========================================================
    localparam logic [7:0] KNOCK_THRESHOLD_ADDR = 8'h1d;
    localparam logic [7:0] KNOCK_MAX_DURATION_ADDR = 8'h21;
    localparam logic [7:0] IRQ_ENABLE_BITS_ADDR = 8'h2e;
    localparam logic [7:0] IRQ_ROUTE_BITS_ADDR = 8'h2f;
    localparam logic [7:0] IRQ_CAUSE_BITS_ADDR = 8'h30;
    localparam logic [7:0] OUTPUT_FORMAT_CTRL_ADDR = 8'h31;
    localparam logic [7:0] SAMPLE_FIRST_ADDR = 8'h32;
    localparam logic [7:0] SAMPLE_LAST_ADDR = 8'h37;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int SAMPLE_READY_BIT = 7;    // In enable, route and cause
    localparam int KNOCK_BIT = 6;           // In enable, route and cause
    localparam int POLARITY_FLIP_BIT = 5;   // In output_format_ctrl

    // ========================================================
    // Reset values and sizes
    // ========================================================
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] NO_BITS = 8'h00;
    localparam int SAMPLE_BYTES = 6;        // Three axes, two bytes each

    // ========================================================
    // Knock detector states
    // ========================================================
    typedef enum logic [1:0] {
        KNOCK_IDLE,   // Below threshold
        KNOCK_ABOVE,  // Above threshold, still short enough
        KNOCK_LONG    // Lasted too long, wait for the drop
    } knock_state_t;

endpackage

`default_nettype wire
